/* File: hw/fem_unit.sv */
// floating-point exception detection, sticky flags, masks and response select
// assumes a datapath that presents operands before computing and rounding status after
// Behaviour
// - six exception classes, each flag and mask
// - invalid, divzero, denormal checked on operands first
// - overflow, underflow, inexact checked on result
// - set flags, masked invalid or divzero gives default result
// - unmasked class signals software handler entry
// - flags stick until software clears them
// - scalar flags and masks at bits 0-5
// - simd flags 0-5, masks 7-12
// - scalar and simd sets fully independent
// - masked response continues same instruction
// - masked invalid writes quiet nan indefinite
// - unmasked invalid traps, operands unchanged
// - masked denormal sets flag, keeps computing
// - unmasked denormal traps, operands unchanged
// - masked divzero returns xor-signed infinity
// - unmasked divzero traps, operands unchanged
`timescale 1ns/1ps

module fem_unit
   import fem_pkg::*;
#(
   parameter int ADDR_W = 8 // register port address width
)
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // pre-computation request
   input wire logic op_valid,
   input wire logic op_simd,
   input wire fem_op_t op_kind,
   input wire logic [31:0] op_a,
   input wire logic [31:0] op_b,
   // pre-computation response
   output logic pre_done,
   output logic pre_use_default,
   output logic [31:0] pre_result,
   output logic pre_proceed,
   output logic pre_trap,
   // post-computation status from the rounding stage
   input wire logic res_valid,
   input wire logic res_simd,
   input wire logic res_overflow,
   input wire logic res_tiny,
   input wire logic res_inexact,
   // post-computation response
   output logic post_done,
   output logic post_trap,
   // interrupt
   output logic irq
);

   // ----------------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------------
   if (ADDR_W < 5 || ADDR_W > 8)
   begin : g_bad_addr
      $error("fem_unit: ADDR_W must lie between 5 and 8");
   end

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [5:0] sc_flags; // scalar stack flags
      logic [5:0] sc_masks; // scalar stack masks
      logic [5:0] sm_flags; // simd flags
      logic [5:0] sm_masks; // simd masks
      logic [1:0] irq_stat; // sticky trap events
      logic [1:0] irq_mask; // trap event enables
      logic [31:0] rdata; // read data, valid one cycle after read strobe
      logic pre_done; // one-cycle response strobe
      logic pre_use_default; // write pre_result instead of computing
      logic [31:0] pre_result; // masked default result
      logic pre_proceed; // datapath goes on computing
      logic pre_trap; // enter software handler
      logic post_done; // one-cycle response strobe
      logic post_trap; // enter software handler
      logic irq; // level interrupt
   } fem_state_t;

   fem_state_t st_r;
   fem_state_t st_nxt;

   // ----------------------------------------------------------------------
   // operand classification helpers
   // ----------------------------------------------------------------------
   // exponent all ones with nonzero fraction
   function automatic logic is_nan(input logic [31:0] v);
      is_nan = (v[30:23] == FEM_EXP_MAX) && (v[22:0] != 23'h000000);
   endfunction

   // signalling nan has the quiet bit clear
   function automatic logic is_snan(input logic [31:0] v);
      is_snan = is_nan(v) && !v[22];
   endfunction

   function automatic logic is_inf(input logic [31:0] v);
      is_inf = (v[30:23] == FEM_EXP_MAX) && (v[22:0] == 23'h000000);
   endfunction

   function automatic logic is_zero(input logic [31:0] v);
      is_zero = (v[30:0] == 31'h00000000);
   endfunction

   function automatic logic is_denorm(input logic [31:0] v);
      is_denorm = (v[30:23] == FEM_EXP_ZERO) && (v[22:0] != 23'h000000);
   endfunction

   // ----------------------------------------------------------------------
   // pre-computation detection, from operands only
   // ----------------------------------------------------------------------
   logic eff_sub; // add of unlike signs or sub of like signs
   logic det_inv;
   logic det_den;
   logic det_zdv;
   logic [5:0] pre_det; // detected classes, positions as in flag fields
   logic [5:0] pre_msk; // masks of the selected set
   logic [5:0] pre_unm; // detected and unmasked

   always_comb
   begin
      eff_sub = (op_a[31] ^ op_b[31]) ^ (op_kind == FEM_OP_SUB);
      // snan operand or an operation with no meaningful result
      det_inv = is_snan(op_a) || is_snan(op_b)
         || ((op_kind == FEM_OP_DIV)
            && ((is_zero(op_a) && is_zero(op_b)) || (is_inf(op_a) && is_inf(op_b))))
         || ((op_kind == FEM_OP_MUL)
            && ((is_inf(op_a) && is_zero(op_b)) || (is_zero(op_a) && is_inf(op_b))))
         || ((op_kind inside {FEM_OP_ADD, FEM_OP_SUB})
            && is_inf(op_a) && is_inf(op_b) && eff_sub);
      det_den = is_denorm(op_a) || is_denorm(op_b);
      // finite nonzero dividend over zero divisor
      det_zdv = (op_kind == FEM_OP_DIV) && is_zero(op_b) && !is_zero(op_a)
         && !is_inf(op_a) && !is_nan(op_a);
      pre_det = 6'h00;
      pre_det[FEM_EX_INV] = det_inv;
      pre_det[FEM_EX_DEN] = det_den;
      pre_det[FEM_EX_ZDV] = det_zdv;
      // each instruction class consults only its own masks
      pre_msk = op_simd ? st_r.sm_masks : st_r.sc_masks;
      pre_unm = pre_det & ~pre_msk;
   end

   // ----------------------------------------------------------------------
   // post-computation detection, from rounding status
   // ----------------------------------------------------------------------
   logic [5:0] post_det;
   logic [5:0] post_msk;

   always_comb
   begin
      post_msk = res_simd ? st_r.sm_masks : st_r.sc_masks;
      post_det = 6'h00;
      post_det[FEM_EX_OVF] = res_overflow;
      // masked underflow reports only tiny and inexact, unmasked any tiny
      post_det[FEM_EX_UNF] = res_tiny && (res_inexact || !post_msk[FEM_EX_UNF]);
      post_det[FEM_EX_INX] = res_inexact;
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   logic [5:0] sc_set; // flags raised this cycle, scalar set
   logic [5:0] sm_set; // flags raised this cycle, simd set
   logic [1:0] irq_set;
   logic [1:0] irq_clr;
   logic wr_sc_st;
   logic wr_sc_ct;
   logic wr_sm;
   logic wr_ist;
   logic wr_imk;

   always_comb
   begin
      st_nxt = st_r;
      // decode writes
      wr_sc_st = reg_wr && (8'(reg_addr) == FEM_ADR_SC_STATUS);
      wr_sc_ct = reg_wr && (8'(reg_addr) == FEM_ADR_SC_CTRL);
      wr_sm = reg_wr && (8'(reg_addr) == FEM_ADR_SIMD_CSR);
      wr_ist = reg_wr && (8'(reg_addr) == FEM_ADR_IRQ_STAT);
      wr_imk = reg_wr && (8'(reg_addr) == FEM_ADR_IRQ_MASK);
      // steer detections only to the set of the issuing instruction
      sc_set = 6'h00;
      sm_set = 6'h00;
      if (op_valid)
      begin
         if (op_simd) sm_set = sm_set | pre_det;
         else sc_set = sc_set | pre_det;
      end
      if (res_valid)
      begin
         if (res_simd) sm_set = sm_set | post_det;
         else sc_set = sc_set | post_det;
      end
      // flags: software write replaces, detection ORs on top so set wins
      if (wr_sc_st)
      begin
         st_nxt.sc_flags = reg_wdata[FEM_FLAG_LSB +: FEM_NUM_EXC];
      end
      st_nxt.sc_flags = st_nxt.sc_flags | sc_set;
      if (wr_sc_ct)
      begin
         st_nxt.sc_masks = reg_wdata[FEM_SC_MASK_LSB +: FEM_NUM_EXC];
      end
      if (wr_sm)
      begin
         st_nxt.sm_flags = reg_wdata[FEM_FLAG_LSB +: FEM_NUM_EXC];
         st_nxt.sm_masks = reg_wdata[FEM_SIMD_MASK_LSB +: FEM_NUM_EXC];
      end
      st_nxt.sm_flags = st_nxt.sm_flags | sm_set;
      // pre-computation response, registered one cycle after the request
      st_nxt.pre_done = op_valid;
      st_nxt.pre_trap = op_valid && (pre_unm != 6'h00);
      st_nxt.pre_use_default = 1'b0;
      st_nxt.pre_result = 32'h00000000;
      st_nxt.pre_proceed = 1'b0;
      if (op_valid && (pre_unm == 6'h00))
      begin
         if (det_inv)
         begin
            // masked invalid overwrites destination with the indefinite
            st_nxt.pre_use_default = 1'b1;
            st_nxt.pre_result = FEM_QNAN_INDEF;
         end
         else if (det_zdv)
         begin
            // masked divide by zero returns infinity signed by xor of signs
            st_nxt.pre_use_default = 1'b1;
            st_nxt.pre_result = {op_a[31] ^ op_b[31], FEM_INF_MAG};
         end
         else
         begin
            // no exception or masked denormal: go on with the operands as given
            st_nxt.pre_proceed = 1'b1;
         end
      end
      // a trap leaves proceed and use_default low so operands stay untouched
      // post-computation response
      st_nxt.post_done = res_valid;
      st_nxt.post_trap = res_valid && ((post_det & ~post_msk) != 6'h00);
      // trap events into sticky interrupt status, set beats clear
      irq_set = 2'h0;
      irq_set[FEM_IRQ_SC] = st_nxt.pre_trap && !op_simd || st_nxt.post_trap && !res_simd;
      irq_set[FEM_IRQ_SIMD] = st_nxt.pre_trap && op_simd || st_nxt.post_trap && res_simd;
      irq_clr = wr_ist ? reg_wdata[1:0] : 2'h0;
      st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_set;
      if (wr_imk)
      begin
         st_nxt.irq_mask = reg_wdata[1:0];
      end
      st_nxt.irq = (st_nxt.irq_stat & st_nxt.irq_mask) != 2'h0;
      // read data for the cycle after the strobe, zero otherwise
      st_nxt.rdata = 32'h00000000;
      if (reg_rd)
      begin
         case (8'(reg_addr))
            FEM_ADR_SC_STATUS: st_nxt.rdata[FEM_FLAG_LSB +: FEM_NUM_EXC] = st_r.sc_flags;
            FEM_ADR_SC_CTRL: st_nxt.rdata[FEM_SC_MASK_LSB +: FEM_NUM_EXC] = st_r.sc_masks;
            FEM_ADR_SIMD_CSR:
            begin
               st_nxt.rdata[FEM_FLAG_LSB +: FEM_NUM_EXC] = st_r.sm_flags;
               st_nxt.rdata[FEM_SIMD_MASK_LSB +: FEM_NUM_EXC] = st_r.sm_masks;
            end
            FEM_ADR_IRQ_STAT: st_nxt.rdata[1:0] = st_r.irq_stat;
            FEM_ADR_IRQ_MASK: st_nxt.rdata[1:0] = st_r.irq_mask;
            // unmapped words read as zero
            default: st_nxt.rdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   // synchronous reset, all classes masked so nothing traps before software sets up
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         st_r <= '0;
         st_r.sc_flags <= FEM_FLAGS_RST;
         st_r.sm_flags <= FEM_FLAGS_RST;
         st_r.sc_masks <= FEM_MASKS_RST;
         st_r.sm_masks <= FEM_MASKS_RST;
         st_r.irq_stat <= FEM_IRQ_RST;
         st_r.irq_mask <= FEM_IRQ_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign reg_rdata = st_r.rdata;
   assign pre_done = st_r.pre_done;
   assign pre_use_default = st_r.pre_use_default;
   assign pre_result = st_r.pre_result;
   assign pre_proceed = st_r.pre_proceed;
   assign pre_trap = st_r.pre_trap;
   assign post_done = st_r.post_done;
   assign post_trap = st_r.post_trap;
   assign irq = st_r.irq;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // a scalar flag once set never drops without a status write
   flag_sticky_a: assert property (!$past(wr_sc_st) && !$past(sys_rst)
      |-> (($past(st_r.sc_flags) & ~st_r.sc_flags) == 6'h00))
      else $error("scalar flag dropped without a write");

   // detection in the clearing cycle still lands
   set_wins_a: assert property (wr_sm && op_valid && op_simd && det_inv
      |=> st_r.sm_flags[FEM_EX_INV])
      else $error("simd invalid flag lost against write");

   // scalar instruction leaves simd flags alone
   sets_indep_a: assert property (op_valid && !op_simd && !res_valid && !wr_sm
      |=> st_r.sm_flags == $past(st_r.sm_flags))
      else $error("scalar op changed simd flags");

   // masked invalid gives the indefinite, no trap
   inv_masked_a: assert property (op_valid && det_inv && pre_unm == 6'h00
      |=> pre_use_default && pre_result == FEM_QNAN_INDEF && !pre_trap)
      else $error("masked invalid result wrong");

   // unmasked pre class traps and writes nothing
   pre_trap_a: assert property (op_valid && pre_unm != 6'h00
      |=> pre_trap && !pre_use_default && !pre_proceed)
      else $error("unmasked pre exception did not trap cleanly");

   // masked divide by zero returns signed infinity
   zdv_masked_a: assert property (op_valid && det_zdv && !det_inv && pre_unm == 6'h00
      |=> pre_result == {$past(op_a[31] ^ op_b[31]), FEM_INF_MAG})
      else $error("divide by zero default wrong");

   // masked denormal keeps the instruction going
   den_masked_a: assert property (op_valid && det_den && !det_inv && !det_zdv
      && pre_unm == 6'h00 |=> pre_proceed && pre_done)
      else $error("masked denormal did not proceed");

   // unmasked post class traps
   post_trap_a: assert property (res_valid && (post_det & ~post_msk) != 6'h00
      |=> post_trap && post_done)
      else $error("unmasked post exception did not trap");

   // masked underflow needs inexact too
   unf_masked_a: assert property (res_valid && !res_simd && res_tiny && !res_inexact
      && st_r.sc_masks[FEM_EX_UNF] && !st_r.sc_flags[FEM_EX_UNF] && !wr_sc_st
      |=> !st_r.sc_flags[FEM_EX_UNF])
      else $error("masked exact tiny result raised underflow");

   // simd csr reads back masks at bits 7..12
   simd_read_a: assert property (reg_rd && 8'(reg_addr) == FEM_ADR_SIMD_CSR
      |=> reg_rdata[FEM_SIMD_MASK_LSB +: FEM_NUM_EXC] == $past(st_r.sm_masks))
      else $error("simd mask readback misplaced");

   // interrupt follows unmasked sticky status
   irq_level_a: assert property (irq == ((st_r.irq_stat & st_r.irq_mask) != 2'h0))
      else $error("interrupt level mismatch");

   // main scenarios
   cov_inv_trap_c: cover property (op_valid && det_inv ##1 pre_trap);
   cov_zdv_def_c: cover property (op_valid && det_zdv ##1 pre_use_default);
   cov_den_unf_c: cover property (pre_proceed ##[1:4] post_done && st_r.sc_flags[FEM_EX_UNF]);
   cov_irq_c: cover property (post_trap ##1 irq);

endmodule

/* File: pkg/fem_pkg.sv */
// shared constants and types of the floating-point exception flag and mask unit
// assumes single-precision operands and a rounding stage that reports its own status
package fem_pkg;

   // ----------------------------------------------------------------------
   // register offsets, byte addresses of aligned 32-bit words
   // ----------------------------------------------------------------------
   localparam logic [7:0] FEM_ADR_SC_STATUS = 8'h00; // scalar stack status word
   localparam logic [7:0] FEM_ADR_SC_CTRL = 8'h04; // scalar stack control word
   localparam logic [7:0] FEM_ADR_SIMD_CSR = 8'h08; // simd fp control and status
   localparam logic [7:0] FEM_ADR_IRQ_STAT = 8'h0C; // sticky trap events, write one to clear
   localparam logic [7:0] FEM_ADR_IRQ_MASK = 8'h10; // interrupt enables

   // ----------------------------------------------------------------------
   // exception class positions, common to flag and mask fields
   // ----------------------------------------------------------------------
   localparam int FEM_NUM_EXC = 6;
   localparam int FEM_EX_INV = 0; // invalid operation
   localparam int FEM_EX_DEN = 1; // denormal operand
   localparam int FEM_EX_ZDV = 2; // divide by zero
   localparam int FEM_EX_OVF = 3; // numeric overflow
   localparam int FEM_EX_UNF = 4; // numeric underflow
   localparam int FEM_EX_INX = 5; // inexact result
   localparam int FEM_FLAG_LSB = 0; // flags at bits 0..5 in all status words
   localparam int FEM_SC_MASK_LSB = 0; // scalar masks at bits 0..5 of control word
   localparam int FEM_SIMD_MASK_LSB = 7; // simd masks at bits 7..12

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [5:0] FEM_FLAGS_RST = 6'h00; // no exceptions recorded
   localparam logic [5:0] FEM_MASKS_RST = 6'h3F; // all classes masked
   localparam logic [1:0] FEM_IRQ_RST = 2'h0;
   localparam int FEM_IRQ_SC = 0; // scalar trap event bit
   localparam int FEM_IRQ_SIMD = 1; // simd trap event bit

   // ----------------------------------------------------------------------
   // single-precision encodings
   // ----------------------------------------------------------------------
   localparam logic [31:0] FEM_QNAN_INDEF = 32'hFFC00000; // quiet nan indefinite
   localparam logic [30:0] FEM_INF_MAG = 31'h7F800000; // infinity without sign
   localparam logic [7:0] FEM_EXP_MAX = 8'hFF;
   localparam logic [7:0] FEM_EXP_ZERO = 8'h00;

   // operation kinds seen by the pre-computation checks
   typedef enum logic [1:0] {FEM_OP_ADD, FEM_OP_SUB, FEM_OP_MUL, FEM_OP_DIV} fem_op_t;

endpackage

/* File: dv/fem_unit_test.sv */
// self-checking bench for the exception flag and mask unit
// assumes the unit alone, driven at its ports, one clock at 40 MHz
`timescale 1ns/1ps

module fem_unit_test
   import fem_pkg::*;
;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic ref_clk, sys_rst, reg_wr, reg_rd, op_valid, op_simd;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, op_a, op_b, pre_result;
   fem_op_t op_kind;
   logic pre_done, pre_use_default, pre_proceed, pre_trap;
   logic res_valid, res_simd, res_overflow, res_tiny, res_inexact, post_done, post_trap, irq;
   int mismatches, cmp_count;
   logic [31:0] q_rd[$]; // expected read words
   logic [34:0] q_pre[$]; // expected {default, proceed, trap, result}
   logic q_post[$]; // expected post trap
   logic [5:0] flg[2], msk[2]; // shadow sets, 0 scalar, 1 simd
   logic [1:0] ist, imk; // shadow trap events and enables
   logic rd_d; // read answer due this cycle
   logic [31:0] va, vb;
   logic [7:0] rexp_adr[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}; // read sweep

   fem_unit i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .op_valid(op_valid), .op_simd(op_simd), .op_kind(op_kind), .op_a(op_a), .op_b(op_b),
      .pre_done(pre_done), .pre_use_default(pre_use_default), .pre_result(pre_result),
      .pre_proceed(pre_proceed), .pre_trap(pre_trap), .res_valid(res_valid),
      .res_simd(res_simd), .res_overflow(res_overflow), .res_tiny(res_tiny),
      .res_inexact(res_inexact), .post_done(post_done), .post_trap(post_trap), .irq(irq));

   // free-running clock, 25 ns period
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ---------------------------------------------------------------
   // comparison and closing
   // ---------------------------------------------------------------
   task chk(input logic [34:0] seen, input logic [34:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_sim();
      chk(q_rd.size() + q_pre.size() + q_post.size(), 0);
      $display("mismatches %0d compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // a read answer stands only in the cycle after the strobe
   always @(posedge ref_clk) rd_d <= reg_rd & ~sys_rst;

   // monitor: each answer takes the oldest note of its kind
   always @(negedge ref_clk)
   begin
      if (rd_d === 1'b1)
         chk(reg_rdata, q_rd.size() ? q_rd.pop_front() : 32'hDEAD);
      else
         chk(reg_rdata, 0);
      if (pre_done === 1'b1)
         chk({pre_use_default, pre_proceed, pre_trap, pre_result},
            q_pre.size() ? q_pre.pop_front() : 35'h0);
      if (post_done === 1'b1)
         chk(post_trap, q_post.size() ? q_post.pop_front() : 1'bx);
   end

   // ---------------------------------------------------------------
   // expectation helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rexp(input logic [7:0] a);
      case (a)
         8'h00: return {26'h0, flg[0]};
         8'h04: return {26'h0, msk[0]};
         8'h08: return {19'h0, msk[1], 1'b0, flg[1]};
         8'h0C: return {30'h0, ist};
         8'h10: return {30'h0, imk};
         default: return 32'h0; // unmapped reads as zero
      endcase
   endfunction

   function automatic logic snan(input logic [31:0] v);
      return v[30:23] == 8'hFF && !v[22] && v[21:0] != 0;
   endfunction

   // pre classes in flag order: bit0 invalid, bit1 denormal, bit2 divzero
   function automatic logic [2:0] pre_cls(input fem_op_t k, input logic [31:0] a, b);
      logic ai, bi, az, bz, inv, den, zdv;
      ai = a[30:0] == 31'h7F800000;
      bi = b[30:0] == 31'h7F800000;
      az = a[30:0] == 0;
      bz = b[30:0] == 0;
      inv = snan(a) | snan(b) | (k == FEM_OP_DIV && ((az && bz) || (ai && bi)))
         | (k == FEM_OP_MUL && ((ai && bz) || (az && bi)))
         | (ai && bi && ((k == FEM_OP_ADD) ^ (a[31] == b[31])) && k != FEM_OP_MUL
            && k != FEM_OP_DIV);
      den = (a[30:23] == 0 && a[22:0] != 0) || (b[30:23] == 0 && b[22:0] != 0);
      zdv = k == FEM_OP_DIV && bz && !az && a[30:23] != 8'hFF;
      return {zdv, den, inv};
   endfunction

   // operand drawn from the special cases, random sign
   function automatic logic [31:0] val();
      logic [31:0] v;
      case ($urandom_range(5))
         0: v = 32'h0;
         1: v = 32'h3F800000;
         2: v = {9'h0, 23'($urandom) | 23'h1}; // denormal
         3: v = 32'h7F800000;
         4: v = 32'h7FC00000;
         default: v = 32'h7F800001; // signalling nan
      endcase
      v[31] = 1'($urandom);
      return v;
   endfunction

   // ---------------------------------------------------------------
   // drivers: request at one edge, taken at the next, then released
   // ---------------------------------------------------------------
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      case (a)
         8'h00: flg[0] = d[5:0];
         8'h04: msk[0] = d[5:0];
         8'h08: {msk[1], flg[1]} = {d[12:7], d[5:0]};
         8'h0C: ist = ist & ~d[1:0];
         8'h10: imk = d[1:0];
         default: ;
      endcase
   endtask

   task rd(input logic [7:0] a);
      q_rd.push_back(rexp(a));
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   task op(input logic s, input fem_op_t k, input logic [31:0] a, b);
      logic [2:0] c;
      logic t;
      logic [31:0] r;
      c = pre_cls(k, a, b);
      t = |(c & ~msk[s][2:0]);
      r = !t && c[0] ? FEM_QNAN_INDEF : !t && c[2] ? {a[31] ^ b[31], FEM_INF_MAG} : 0;
      q_pre.push_back({!t && (c[0] | c[2]), !t && !(c[0] | c[2]), t, r});
      flg[s] = flg[s] | {3'h0, c};
      if (t) ist[s] = 1'b1;
      @(posedge ref_clk);
      {op_simd, op_a, op_b, op_valid} <= {s, a, b, 1'b1};
      op_kind <= k;
      @(posedge ref_clk);
      op_valid <= 1'b0;
   endtask

   task post(input logic s, o, ti, ix);
      logic u, t;
      u = msk[s][4] ? ti & ix : ti;
      t = (o & !msk[s][3]) | (u & !msk[s][4]) | (ix & !msk[s][5]);
      flg[s] = flg[s] | {ix, u, o, 3'h0};
      if (t) ist[s] = 1'b1;
      q_post.push_back(t);
      @(posedge ref_clk);
      {res_simd, res_overflow, res_tiny, res_inexact, res_valid} <= {s, o, ti, ix, 1'b1};
      @(posedge ref_clk);
      res_valid <= 1'b0;
   endtask

   task rd_all();
      foreach (rexp_adr[j]) rd(rexp_adr[j]);
   endtask

   task ck_irq();
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(irq, |(ist & imk));
   endtask

   // ---------------------------------------------------------------
   // watchdog and main sequence
   // ---------------------------------------------------------------
   initial
   begin
      #500000;
      mismatches++;
      end_sim();
   end

   initial
   begin
      {sys_rst, reg_wr, reg_rd, op_valid, res_valid} = 5'h10;
      {reg_addr, reg_wdata, op_a, op_b, op_simd} = '0;
      op_kind = FEM_OP_ADD;
      {res_simd, res_overflow, res_tiny, res_inexact} = 4'h0;
      flg = '{2{FEM_FLAGS_RST}};
      msk = '{2{FEM_MASKS_RST}};
      {ist, imk, mismatches, cmp_count} = '0;
      void'($urandom(32'h5CDD));
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd_all();
      wr(8'h14, 32'hFFFFFFFF);
      rd(8'h14);
      op(1'b0, FEM_OP_DIV, 32'h3F800000, 32'h0);
      op(1'b1, FEM_OP_DIV, 32'hBF800000, 32'h0);
      rd_all();
      wr(8'h04, 32'h3B);
      wr(8'h10, 32'h3);
      op(1'b0, FEM_OP_DIV, 32'h3F800000, 32'h80000000);
      ck_irq();
      wr(8'h0C, 32'h1);
      ck_irq();
      for (int i = 0; i < 80; i++)
      begin
         if (i % 8 == 0)
         begin
            wr(8'h04, $urandom);
            wr(8'h08, {19'h0, 6'($urandom), 1'b0, flg[1]});
         end
         va = val();
         vb = val();
         if (snan(va)) vb = 32'h3F800000;
         if (snan(vb)) va = 32'h3F800000;
         op(1'($urandom), fem_op_t'($urandom_range(3)), va, vb);
         post(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
         ck_irq();
         if (i % 16 == 15) rd_all();
         if (i == 40) wr(8'h10, 32'h2);
      end
      wr(8'h00, 32'h0);
      // simd clear in the very cycle of a simd invalid: the new flag must survive
      fork
         wr(8'h08, {19'h0, msk[1], 7'h0});
         op(1'b1, FEM_OP_ADD, 32'h7F800001, 32'h3F800000);
      join
      flg[1][FEM_EX_INV] = 1'b1;
      wr(8'h0C, 32'h3);
      rd_all();
      ck_irq();
      end_sim();
   end
endmodule
